//--- core/radio_link_pkg.sv
// Types shared by the radio link transaction block.
// Assumes nothing outside itself.
package radio_link_pkg;
  typedef enum logic [2:0] {
    standby1, standby2, tx_mode, rx_wait_ack, retry_delay, rx_search, tx_ack
  } phase_type;
endpackage

//--- core/radio_link_regs.svh
// Register offsets, reset values and timing constants of the radio link transaction block.
// Assumes a 10 MHz pclk and APB with 32-bit aligned registers.
`ifndef RADIO_LINK_REGS_SVH
`define RADIO_LINK_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_CONTROL 12'h000
`define OFF_RETRY_SETUP 12'h004
`define OFF_PIPE_ENABLE 12'h008
`define OFF_PIPE0_ADDR_LO 12'h00C
`define OFF_PIPE0_ADDR_HI 12'h010
`define OFF_PIPEX_ADDR_LO 12'h014
`define OFF_PIPEX_ADDR_HI 12'h018
`define OFF_PIPE_LSB 12'h01C
`define OFF_COMMON 12'h020
`define OFF_STATUS 12'h024
`define OFF_EVENT 12'h028
`define OFF_ACK_PAYLOAD 12'h02C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PIPE_ENABLE 6'h03
`define RST_RETRY_SETUP 8'h03
`define RST_PIPE_LSB 40'hC6C5C4C3C2

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 10
`define DELAY_STEP_US 250
`define DELAY_STEP_CYC 12'(`DELAY_STEP_US * `CLK_MHZ)
`define MATCH_WAIT_US 250
`define MATCH_WAIT_CYC 12'(`MATCH_WAIT_US * `CLK_MHZ)

`endif

//--- core/radio_link_transaction_fsm.sv
// Link-layer transaction state machine of a packet radio with APB registers.
// Assumes a modem outside that sends, receives and matches addresses as told.
// Function
// - Transmitter with radio enable and queued packet sends that packet.
// - After send, unless skip-ack set, listen for acknowledgement.
// - Empty acknowledgement raises only transmit-done.
// - Payload acknowledgement raises transmit-done and receive-ready together, then standby one.
// - Acknowledge timeout goes to retry delay until retransmit delay ends.
// - Below retry limit after delay, resend same packet.
// - Retry limit reached raises retry-limit event, back to standby one.
// - Transmitter enabled with empty transmit FIFO sits in standby two.
// - Receiver with radio enable searches the air continuously.
// - Auto-ack receiver tells new from repeat; new goes to FIFO, receive-ready.
// - Receiver raises transmit-done when next packet confirms payload acknowledgement.
// - Skip-ack clear sends acknowledgement with queued payload, then receive again.
// - Repeated packet payload dropped but still acknowledged.
// - Incoming address compared against all six pipes in parallel.
// - Only one pipe receives at a time until its packet completes.
// - Per-pipe enable bits, pipes 0 and 1 enabled after reset.
// - Pipe 0 own five-byte address; pipes 1-5 share upper four bytes.
// - CRC, widths, channel, rate, gain common; CRC forced on with auto-ack.
// - Acknowledgement goes to the address of the receiving pipe.
// - Every autonomous sequence ends with the radio interrupt.
// - Retransmit delay programmable in 250 us steps.
// - Ack wait ends if no address match in 250 us, or after packet.
`timescale 1ns/1ns
`include "radio_link_regs.svh"
module radio_link_transaction_fsm (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Transmit FIFO status and pop
  input wire logic tx_fifo_has_data,
  input wire logic tx_skip_ack,
  output logic tx_fifo_pop,
  // Modem requests
  output logic modem_tx_start,
  output logic modem_tx_is_ack,
  output logic modem_rx_on,
  output logic [39:0] modem_tx_address,
  output logic [39:0] modem_rx_address0,
  output logic [5:0] modem_pipe_match_mask,
  // Modem reports (same clock)
  input wire logic modem_tx_end,
  input wire logic [39:0] rx_address,
  input wire logic rx_address_valid,
  input wire logic rx_packet_end,
  input wire logic rx_crc_ok,
  input wire logic rx_has_payload,
  input wire logic rx_skip_ack,
  input wire logic [1:0] rx_packet_id,
  // Receive FIFO push
  output logic rx_fifo_push,
  output logic [2:0] rx_fifo_pipe,
  // Common settings out
  output logic crc_on,
  output logic [7:0] common_settings,
  // Events
  output logic tx_done_irq,
  output logic rx_ready_irq,
  output logic retry_limit_irq,
  output logic radio_interrupt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    radio_link_pkg::phase_type phase;
    logic rf_enable;
    logic role_rx;
    logic auto_ack;
    logic [7:0] retry_setup_reg;
    logic [5:0] pipe_enable_mask;
    logic [39:0] pipe0_rx_address;
    logic [31:0] pipex_upper;
    logic [39:0] pipe_lsb;
    logic [7:0] common;
    logic [3:0] retry_count;
    logic [15:0] timer;
    logic matched;
    logic [2:0] active_pipe;
    logic pipe_busy;
    logic ack_payload_pending;
    logic ack_payload_sent;
    logic [11:0] last_id;
    logic [5:0] id_valid;
    logic [3:0] sticky;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic tx_fifo_pop;
    logic modem_tx_start;
    logic modem_tx_is_ack;
    logic [39:0] modem_tx_address;
    logic rx_fifo_push;
    logic [2:0] rx_fifo_pipe;
    logic tx_done_irq;
    logic rx_ready_irq;
    logic retry_limit_irq;
    logic radio_interrupt;
    logic modem_rx_on;
    logic crc_on;
  } state_type;

  state_type cur;
  state_type next_cur;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Full address of pipe n; pipes 1-5 share the upper bytes
  function automatic logic [39:0] pipe_addr(input state_type s, input logic [2:0] n);
    logic [39:0] a;
    logic [2:0] slot;
    slot = (n == 3'h0) ? 3'h0 : n - 3'h1;
    a = {s.pipex_upper, s.pipe_lsb[8*slot +: 8]};
    if (n == 3'h0) begin
      a = s.pipe0_rx_address;
    end
    return a;
  endfunction

  // Parallel compare of all six pipes
  logic [5:0] match_vec;
  logic [2:0] match_pipe;
  logic match_any;
  always_comb begin
    match_vec = 6'h00;
    match_pipe = 3'h0;
    for (int i = 0; i < 6; i++) begin
      match_vec[i] = cur.pipe_enable_mask[i] &&
        (rx_address == pipe_addr(cur, 3'(i)));
    end
    for (int i = 5; i >= 0; i--) begin
      if (match_vec[i]) begin
        match_pipe = 3'(i);
      end
    end
  end
  assign match_any = |match_vec;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic apb_write;
  logic [15:0] delay_cycles;
  logic [1:0] seen_id;
  logic is_repeat;
  always_comb begin
    next_cur = cur;
    apb_write = psel && penable && pwrite && cur.pready;
    // Pulses last one cycle
    next_cur.tx_fifo_pop = 1'b0;
    next_cur.modem_tx_start = 1'b0;
    next_cur.rx_fifo_push = 1'b0;
    next_cur.tx_done_irq = 1'b0;
    next_cur.rx_ready_irq = 1'b0;
    next_cur.retry_limit_irq = 1'b0;
    next_cur.radio_interrupt = 1'b0;
    next_cur.pready = 1'b0;
    next_cur.pslverr = 1'b0;
    delay_cycles = 16'(({12'h000, cur.retry_setup_reg[7:4]} + 16'h0001) *
      {4'h0, `DELAY_STEP_CYC});
    seen_id = cur.last_id[2*cur.active_pipe +: 2];
    is_repeat = cur.id_valid[cur.active_pipe] && (seen_id == rx_packet_id);
    if (cur.timer != 16'h0000) begin
      next_cur.timer = cur.timer - 16'h0001;
    end

    // Transaction sequencing
    unique case (cur.phase)
      radio_link_pkg::standby1, radio_link_pkg::standby2: begin
        if (cur.rf_enable && cur.role_rx) begin
          next_cur.phase = radio_link_pkg::rx_search;
        end else if (cur.rf_enable && tx_fifo_has_data && !cur.tx_fifo_pop &&
            !cur.retry_limit_irq) begin
          next_cur.phase = radio_link_pkg::tx_mode;
          next_cur.modem_tx_start = 1'b1;
          next_cur.modem_tx_is_ack = 1'b0;
          next_cur.modem_tx_address = cur.pipe0_rx_address;
          next_cur.retry_count = 4'h0;
        end else if (cur.rf_enable) begin
          next_cur.phase = radio_link_pkg::standby2;
        end else begin
          next_cur.phase = radio_link_pkg::standby1;
        end
      end
      radio_link_pkg::tx_mode: begin
        if (modem_tx_end) begin
          if (cur.auto_ack && !tx_skip_ack) begin
            next_cur.phase = radio_link_pkg::rx_wait_ack;
            next_cur.timer = delay_cycles;
            next_cur.matched = 1'b0;
          end else begin
            next_cur.phase = radio_link_pkg::standby1;
            next_cur.tx_fifo_pop = 1'b1;
            next_cur.tx_done_irq = 1'b1;
            next_cur.radio_interrupt = 1'b1;
          end
        end
      end
      radio_link_pkg::rx_wait_ack: begin
        if (rx_address_valid && rx_address == cur.pipe0_rx_address) begin
          next_cur.matched = 1'b1;
        end
        if (cur.matched && rx_packet_end && rx_crc_ok) begin
          next_cur.phase = radio_link_pkg::standby1;
          next_cur.tx_fifo_pop = 1'b1;
          next_cur.tx_done_irq = 1'b1;
          next_cur.rx_ready_irq = rx_has_payload;
          next_cur.rx_fifo_push = rx_has_payload;
          next_cur.rx_fifo_pipe = 3'h0;
          next_cur.radio_interrupt = 1'b1;
        end else if ((cur.matched && rx_packet_end) || cur.timer == 16'h0000 ||
            (!cur.matched && delay_cycles - cur.timer >= {4'h0, `MATCH_WAIT_CYC})) begin
          next_cur.phase = radio_link_pkg::retry_delay;
        end
      end
      radio_link_pkg::retry_delay: begin
        if (cur.timer == 16'h0000) begin
          if (cur.retry_count < cur.retry_setup_reg[3:0]) begin
            next_cur.retry_count = cur.retry_count + 4'h1;
            next_cur.phase = radio_link_pkg::tx_mode;
            next_cur.modem_tx_start = 1'b1;
          end else begin
            next_cur.phase = radio_link_pkg::standby1;
            next_cur.retry_limit_irq = 1'b1;
            next_cur.radio_interrupt = 1'b1;
          end
        end
      end
      radio_link_pkg::rx_search: begin
        if (!cur.rf_enable) begin
          next_cur.phase = radio_link_pkg::standby1;
          next_cur.pipe_busy = 1'b0;
        end else if (rx_address_valid && match_any && !cur.pipe_busy) begin
          next_cur.pipe_busy = 1'b1;
          next_cur.active_pipe = match_pipe;
        end else if (cur.pipe_busy && rx_packet_end) begin
          next_cur.pipe_busy = 1'b0;
          if (rx_crc_ok) begin
            next_cur.radio_interrupt = 1'b1;
            if (cur.ack_payload_sent) begin
              next_cur.tx_done_irq = 1'b1;
              next_cur.tx_fifo_pop = 1'b1;
              next_cur.ack_payload_sent = 1'b0;
            end
            if (!(cur.auto_ack && is_repeat)) begin
              next_cur.rx_fifo_push = 1'b1;
              next_cur.rx_fifo_pipe = cur.active_pipe;
              next_cur.rx_ready_irq = 1'b1;
            end
            next_cur.last_id[2*cur.active_pipe +: 2] = rx_packet_id;
            next_cur.id_valid[cur.active_pipe] = 1'b1;
            if (cur.auto_ack && !rx_skip_ack) begin
              next_cur.phase = radio_link_pkg::tx_ack;
              next_cur.modem_tx_start = 1'b1;
              next_cur.modem_tx_is_ack = 1'b1;
              next_cur.modem_tx_address = pipe_addr(cur, cur.active_pipe);
              next_cur.ack_payload_sent = cur.ack_payload_pending;
            end
          end
        end
      end
      radio_link_pkg::tx_ack: begin
        if (modem_tx_end) begin
          next_cur.phase = radio_link_pkg::rx_search;
        end
      end
      default: begin
        next_cur.phase = radio_link_pkg::standby1;
      end
    endcase

    // Sticky event view for software; set wins over clear
    if (apb_write && paddr == `OFF_EVENT) begin
      next_cur.sticky = cur.sticky & ~pwdata[3:0];
    end
    next_cur.sticky = next_cur.sticky | {next_cur.radio_interrupt,
      next_cur.retry_limit_irq, next_cur.rx_ready_irq, next_cur.tx_done_irq};

    // APB: one wait state, answer in the cycle after the access starts
    if (psel && penable && !cur.pready) begin
      next_cur.pready = 1'b1;
      next_cur.prdata = 32'h0000_0000;
      unique case (paddr)
        `OFF_CONTROL: next_cur.prdata = {29'h0, cur.auto_ack, cur.role_rx, cur.rf_enable};
        `OFF_RETRY_SETUP: next_cur.prdata = {24'h0, cur.retry_setup_reg};
        `OFF_PIPE_ENABLE: next_cur.prdata = {26'h0, cur.pipe_enable_mask};
        `OFF_PIPE0_ADDR_LO: next_cur.prdata = cur.pipe0_rx_address[31:0];
        `OFF_PIPE0_ADDR_HI: next_cur.prdata = {24'h0, cur.pipe0_rx_address[39:32]};
        `OFF_PIPEX_ADDR_LO: next_cur.prdata = cur.pipex_upper;
        `OFF_PIPEX_ADDR_HI: next_cur.prdata = cur.pipe_lsb[39:8];
        `OFF_PIPE_LSB: next_cur.prdata = {24'h0, cur.pipe_lsb[7:0]};
        `OFF_COMMON: next_cur.prdata = {24'h0, cur.common};
        `OFF_STATUS: next_cur.prdata = {21'h0, cur.active_pipe, cur.retry_count,
          1'b0, cur.phase};
        `OFF_EVENT: next_cur.prdata = {28'h0, cur.sticky};
        `OFF_ACK_PAYLOAD: next_cur.prdata = {31'h0, cur.ack_payload_pending};
        default: next_cur.pslverr = 1'b1;
      endcase
    end
    // Register writes take effect at the completing edge
    if (apb_write) begin
      unique case (paddr)
        `OFF_CONTROL: begin
          next_cur.rf_enable = pwdata[0];
          next_cur.role_rx = pwdata[1];
          next_cur.auto_ack = pwdata[2];
        end
        `OFF_RETRY_SETUP: next_cur.retry_setup_reg = pwdata[7:0];
        `OFF_PIPE_ENABLE: next_cur.pipe_enable_mask = pwdata[5:0];
        `OFF_PIPE0_ADDR_LO: next_cur.pipe0_rx_address[31:0] = pwdata;
        `OFF_PIPE0_ADDR_HI: next_cur.pipe0_rx_address[39:32] = pwdata[7:0];
        `OFF_PIPEX_ADDR_LO: next_cur.pipex_upper = pwdata;
        `OFF_PIPEX_ADDR_HI: next_cur.pipe_lsb[39:8] = pwdata;
        `OFF_PIPE_LSB: next_cur.pipe_lsb[7:0] = pwdata[7:0];
        `OFF_COMMON: next_cur.common = pwdata[7:0];
        `OFF_ACK_PAYLOAD: next_cur.ack_payload_pending = pwdata[0];
        default: begin
        end
      endcase
    end

    // Decoded outputs registered too
    next_cur.modem_rx_on = next_cur.phase inside {radio_link_pkg::rx_wait_ack,
      radio_link_pkg::rx_search};
    next_cur.crc_on = next_cur.common[0] | next_cur.auto_ack;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.phase <= radio_link_pkg::standby1;
      cur.retry_setup_reg <= `RST_RETRY_SETUP;
      cur.pipe_enable_mask <= `RST_PIPE_ENABLE;
      cur.pipe_lsb <= `RST_PIPE_LSB;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign tx_fifo_pop = cur.tx_fifo_pop;
  assign modem_tx_start = cur.modem_tx_start;
  assign modem_tx_is_ack = cur.modem_tx_is_ack;
  assign modem_rx_on = cur.modem_rx_on;
  assign modem_tx_address = cur.modem_tx_address;
  assign modem_rx_address0 = cur.pipe0_rx_address;
  assign modem_pipe_match_mask = cur.pipe_enable_mask;
  assign rx_fifo_push = cur.rx_fifo_push;
  assign rx_fifo_pipe = cur.rx_fifo_pipe;
  assign crc_on = cur.crc_on;
  assign common_settings = cur.common;
  assign tx_done_irq = cur.tx_done_irq;
  assign rx_ready_irq = cur.rx_ready_irq;
  assign retry_limit_irq = cur.retry_limit_irq;
  assign radio_interrupt = cur.radio_interrupt;

endmodule

//--- test/radio_link_monitor.sv
// Checker watching the ports of the radio link transaction block.
// Assumes one clock pclk and the asynchronous active-low presetn.
`timescale 1ns/1ns
module radio_link_monitor (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Link side
  input wire logic tx_skip_ack,
  input wire logic modem_tx_start,
  input wire logic modem_tx_is_ack,
  input wire logic modem_rx_on,
  input wire logic [39:0] modem_tx_address,
  input wire logic modem_tx_end,
  input wire logic [39:0] rx_address,
  input wire logic rx_address_valid,
  input wire logic rx_packet_end,
  input wire logic rx_crc_ok,
  input wire logic rx_has_payload,
  input wire logic rx_fifo_push,
  // Events
  input wire logic tx_done_irq,
  input wire logic rx_ready_irq,
  input wire logic retry_limit_irq,
  input wire logic radio_interrupt
);
  logic [39:0] last_addr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Address of the packet in flight, the one an acknowledgement must go back to
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) last_addr <= '0;
    else if (rx_address_valid) last_addr <= rx_address;
  end
  property p_apb_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer late");
  property p_apb_err;
    pslverr |-> pready && psel && penable;
  endproperty
  a_apb_err: assert property (p_apb_err) else $error("error outside access");
  property p_irq_end;
    tx_done_irq || retry_limit_irq |-> radio_interrupt;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("sequence end without interrupt");
  property p_push_cause;
    rx_fifo_push |-> $past(rx_packet_end && rx_crc_ok);
  endproperty
  a_push_cause: assert property (p_push_cause) else $error("push without good packet");
  property p_rdy_cause;
    rx_ready_irq |-> $past(rx_packet_end && rx_crc_ok && rx_has_payload);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("receive ready without payload");
  property p_ack_addr;
    modem_tx_start && modem_tx_is_ack |-> modem_tx_address == last_addr;
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("ack to wrong address");
  property p_tx_listen;
    modem_tx_end && !modem_tx_is_ack && !tx_skip_ack |-> ##[1:3] modem_rx_on;
  endproperty
  a_tx_listen: assert property (p_tx_listen) else $error("no listen after send");
  property p_limit_idle;
    retry_limit_irq |-> !modem_rx_on && !modem_tx_is_ack;
  endproperty
  a_limit_idle: assert property (p_limit_idle) else $error("not idle at retry limit");
  // Main scenarios reached
  c_both: cover property (tx_done_irq && rx_ready_irq);
  c_limit: cover property (retry_limit_irq);
  c_ack: cover property (modem_tx_start && modem_tx_is_ack);
endmodule
bind radio_link_transaction_fsm radio_link_monitor radio_link_monitor_inst (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .tx_skip_ack, .modem_tx_start, .modem_tx_is_ack,
  .modem_rx_on, .modem_tx_address, .modem_tx_end, .rx_address, .rx_address_valid,
  .rx_packet_end, .rx_crc_ok, .rx_has_payload, .rx_fifo_push, .tx_done_irq, .rx_ready_irq,
  .retry_limit_irq, .radio_interrupt);

//--- test/radio_peer_model.sv
// Behavioural peer radio and modem: sends, acknowledges and injects packets.
// Assumes the block's modem ports on the same pclk.
`timescale 1ns/1ns
module radio_peer_model (
  // Clock
  input wire logic pclk,
  // Block requests
  input wire logic modem_tx_start,
  input wire logic modem_tx_is_ack,
  input wire logic modem_rx_on,
  input wire logic [39:0] modem_rx_address0,
  // Bench control: 0 no ack, 1 empty ack, 2 ack with payload
  input wire logic [1:0] ack_mode,
  input wire logic slow,
  // Reports to the block
  output logic modem_tx_end = 1'b0,
  output logic [39:0] rx_address = 40'h0,
  output logic rx_address_valid = 1'b0,
  output logic rx_packet_end = 1'b0,
  output logic rx_crc_ok = 1'b0,
  output logic rx_has_payload = 1'b0,
  output logic rx_skip_ack = 1'b0,
  output logic [1:0] rx_packet_id = 2'h0
);
  logic is_ack;
  // One packet on air; fields are scrambled once they are no longer valid
  task air_packet(input logic [39:0] a, input logic [1:0] id, input logic sk, input logic pay);
    @(posedge pclk);
    rx_address <= a;
    rx_address_valid <= 1'b1;
    @(posedge pclk);
    rx_address_valid <= 1'b0;
    rx_address <= ~a;
    repeat (4) @(posedge pclk);
    {rx_packet_end, rx_crc_ok, rx_has_payload, rx_skip_ack, rx_packet_id} <= {2'b11, pay, sk, id};
    @(posedge pclk);
    {rx_packet_end, rx_crc_ok, rx_has_payload, rx_skip_ack, rx_packet_id} <= {2'b00, ~pay, ~sk, ~id};
  endtask
  // Send takes a short or long air time; a data packet may be answered
  always @(posedge pclk) begin
    if (modem_tx_start === 1'b1) begin
      is_ack = modem_tx_is_ack;
      repeat (slow ? 40 : 4) @(posedge pclk);
      modem_tx_end <= 1'b1;
      @(posedge pclk);
      modem_tx_end <= 1'b0;
      repeat (3) @(posedge pclk);
      // Reply only reaches a listening block, on the address it listens to
      if (!is_ack && ack_mode != 2'h0 && modem_rx_on)
        air_packet(modem_rx_address0, 2'h0, 1'b0, ack_mode == 2'h2);
    end
  end
endmodule

//--- test/test_radio_link_transaction_fsm.sv
// Self-checking bench of the radio link transaction block with a peer model.
// Assumes the block's register offsets header and a 10 MHz pclk.
`timescale 1ns/1ns
`include "radio_link_regs.svh"
module test_radio_link_transaction_fsm;
  // Bus and control
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, rerr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic tx_fifo_has_data = 0, tx_skip_ack = 0, tx_fifo_pop, slow = 0, sk;
  logic [1:0] ack_mode = 0, id, last_id;
  // Modem side
  logic modem_tx_start, modem_tx_is_ack, modem_rx_on, modem_tx_end;
  logic rx_address_valid, rx_packet_end, rx_crc_ok, rx_has_payload, rx_skip_ack;
  logic [39:0] modem_tx_address, modem_rx_address0, rx_address, a0;
  logic [5:0] modem_pipe_match_mask;
  logic [1:0] rx_packet_id;
  logic rx_fifo_push, crc_on, tx_done_irq, rx_ready_irq, retry_limit_irq, radio_interrupt;
  logic [2:0] rx_fifo_pipe;
  logic [7:0] common_settings;
  int n_errors = 0, tests_run = 0, cyc = 0, pend = 0, seed = 49714, gap = 0, last_end = 0, i;
  int ev[8] = '{default: 0};
  int b[8];
  always #50 pclk = ~pclk;
  radio_link_transaction_fsm radio_link_transaction_fsm_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tx_fifo_has_data,
    .tx_skip_ack, .tx_fifo_pop, .modem_tx_start, .modem_tx_is_ack, .modem_rx_on,
    .modem_tx_address, .modem_rx_address0, .modem_pipe_match_mask, .modem_tx_end, .rx_address,
    .rx_address_valid, .rx_packet_end, .rx_crc_ok, .rx_has_payload, .rx_skip_ack, .rx_packet_id,
    .rx_fifo_push, .rx_fifo_pipe, .crc_on, .common_settings, .tx_done_irq, .rx_ready_irq,
    .retry_limit_irq, .radio_interrupt);
  radio_peer_model radio_peer_model_inst (.pclk, .modem_tx_start, .modem_tx_is_ack,
    .modem_rx_on, .modem_rx_address0, .ack_mode, .slow, .modem_tx_end, .rx_address,
    .rx_address_valid, .rx_packet_end, .rx_crc_ok, .rx_has_payload, .rx_skip_ack, .rx_packet_id);
  // ----------------------------------------------------------------
  // Event counting, transmit FIFO stand-in and timeout
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (tx_fifo_pop === 1'b1) begin
      pend <= pend - 1;
      tx_fifo_has_data <= pend > 1;
    end
    if (retry_limit_irq === 1'b1) tx_fifo_has_data <= 1'b0;
    ev[0] <= ev[0] + (tx_done_irq === 1'b1);
    ev[1] <= ev[1] + (rx_ready_irq === 1'b1);
    ev[2] <= ev[2] + (tx_done_irq === 1'b1 && rx_ready_irq === 1'b1);
    ev[3] <= ev[3] + (rx_fifo_push === 1'b1);
    ev[4] <= ev[4] + (modem_tx_start === 1'b1 && modem_tx_is_ack === 1'b1);
    ev[5] <= ev[5] + (retry_limit_irq === 1'b1);
    ev[6] <= ev[6] + (modem_tx_start === 1'b1 && modem_tx_is_ack === 1'b0);
    if (modem_tx_end === 1'b1) last_end <= cyc;
    if (modem_tx_start === 1'b1) gap <= cyc - last_end;
    // Whole run needs about 21000 cycles
    if (cyc == 70000) begin
      n_errors++;
      end_of_test();
    end
  end
  task check(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // One APB transfer; waits up to 50 cycles for pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) check(0, 1, "bus hang");
  endtask
  task wait_ev(input int k, input int n, input int lim);
    while (ev[k] < n && lim > 0) begin
      @(posedge pclk);
      lim--;
    end
  endtask
  // Receive-ready rides along only on a payload acknowledgement that was awaited
  function logic [31:0] exp_rdy(input logic [1:0] m, input logic s);
    return {31'h0, m == 2'h2 && !s};
  endfunction
  task end_of_test();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    check(modem_pipe_match_mask, 6'h03, "mask at reset");
    apb(0, `OFF_PIPE_ENABLE, 0);
    check(rd, 32'h3, "pipe enable reset");
    apb(0, `OFF_RETRY_SETUP, 0);
    check(rd, 32'h3, "retry setup reset");
    apb(1, 12'h030, 32'hFFFFFFFF);
    check(rerr, 1'b1, "unmapped access");
    $display("test reset done");
    a0 = {8'($random(seed)) | 8'h80, 32'($random(seed))};
    apb(1, `OFF_PIPE0_ADDR_LO, a0[31:0]);
    apb(1, `OFF_PIPE0_ADDR_HI, {24'h0, a0[39:32]});
    apb(1, `OFF_CONTROL, 32'h5);
    for (i = 0; i < 6; i++) begin
      b = ev;
      sk = (i == 5) ? 1'b1 : 1'($random(seed));
      {ack_mode, slow, tx_skip_ack} <= {2'({$random(seed)} % 2 + 1), 1'($random(seed)), sk};
      pend <= 1;
      tx_fifo_has_data <= 1'b1;
      wait_ev(0, b[0] + 1, 3000);
      repeat (10) @(posedge pclk);
      check(ev[0] - b[0], 1, "tx done count");
      check(ev[1] - b[1], exp_rdy(ack_mode, sk), "rx ready count");
      check(ev[2] - b[2], exp_rdy(ack_mode, sk), "joint events");
      check(modem_rx_on, 1'b0, "idle with empty fifo");
    end
    $display("test transmit done");
    apb(1, `OFF_RETRY_SETUP, 32'h13);
    b = ev;
    {ack_mode, tx_skip_ack} <= 3'b000;
    pend <= 1;
    tx_fifo_has_data <= 1'b1;
    wait_ev(6, b[6] + 2, 10000);
    check(gap >= 5000 && gap <= 5010, 1, "retransmit gap");
    wait_ev(5, b[5] + 1, 30000);
    check(ev[6] - b[6], 4, "sends until limit");
    check(ev[5] - b[5], 1, "retry limit event");
    apb(1, `OFF_CONTROL, 32'h0);
    $display("test retry done");
    apb(1, `OFF_CONTROL, 32'h7);
    repeat (3) @(posedge pclk);
    check(modem_rx_on, 1'b1, "searching");
    last_id = 2'h3;
    for (i = 0; i < 6; i++) begin
      b = ev;
      id = (i == 0) ? 2'h3 : 2'({$random(seed)} % 2 + 2);
      sk = 1'($random(seed));
      radio_peer_model_inst.air_packet(a0, id, sk, 1'b1);
      repeat (80) @(posedge pclk);
      check(ev[3] - b[3], (i == 0 || id != last_id), "push on new");
      check(ev[4] - b[4], !sk, "ack sent");
      last_id = id;
    end
    apb(1, `OFF_ACK_PAYLOAD, 32'h1);
    b = ev;
    radio_peer_model_inst.air_packet(a0, 2'h0, 1'b0, 1'b1);
    repeat (80) @(posedge pclk);
    radio_peer_model_inst.air_packet(a0, 2'h1, 1'b0, 1'b1);
    repeat (80) @(posedge pclk);
    check(ev[0] - b[0], 1, "payload ack confirmed");
    apb(1, `OFF_PIPE_ENABLE, 32'h2);
    b = ev;
    radio_peer_model_inst.air_packet(a0, 2'h2, 1'b0, 1'b1);
    repeat (80) @(posedge pclk);
    check(modem_pipe_match_mask, 6'h02, "mask written");
    check(ev[3] - b[3] + ev[4] - b[4], 0, "disabled pipe ignored");
    $display("test receive done");
    end_of_test();
  end
endmodule
